// *** hw/uart_irq_pkg.sv ***
package uart_irq_pkg;

  // ----------------------------------------------------------------
  // register addresses on the three-bit port
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_HOLDING = 3'h0;
  localparam logic [2:0] ADDR_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [7:0] LCR_ENHANCED_KEY = 8'hbf;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam int IE_SLEEP = 4;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  localparam logic [7:0] IE_BASIC_MASK = 8'h0f;
  localparam int EF_ENH = 4;
  localparam int EF_RTS = 6;
  localparam int EF_CTS = 7;
  localparam int FC_EN = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int LC_DIV = 7;
  localparam int LC_PAR = 3;
  localparam int LC_STOP = 2;

  // ----------------------------------------------------------------
  // status codes, bits [5:0]
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
  localparam logic [5:0] CODE_RECEIVE_READY_EVENT = 6'h04;
  localparam logic [5:0] CODE_TRANSMIT_READY_EVENT = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;

  // ----------------------------------------------------------------
  // trigger levels and timeout span
  // ----------------------------------------------------------------
  localparam logic [5:0] RX_TRIG_0 = 6'h08;
  localparam logic [5:0] RX_TRIG_1 = 6'h10;
  localparam logic [5:0] RX_TRIG_2 = 6'h18;
  localparam logic [5:0] RX_TRIG_3 = 6'h1c;
  localparam logic [5:0] TX_TRIG_0 = 6'h10;
  localparam logic [5:0] TX_TRIG_1 = 6'h08;
  localparam logic [5:0] TX_TRIG_2 = 6'h18;
  localparam logic [5:0] TX_TRIG_3 = 6'h1e;
  localparam logic [6:0] TOUT_CHARS = 7'h04;
  localparam logic [6:0] TOUT_EXTRA_BITS = 7'h0c;
  localparam logic [6:0] FRAME_BASE_BITS = 7'h07;

  // ----------------------------------------------------------------
  // carriers from the channel datapaths
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] count;
    logic push;
    logic [7:0] head_data;
    logic [2:0] head_err;
    logic any_err;
    logic overrun;
    logic bit_tick;
  } rx_stat_t;

  typedef struct packed {
    logic [5:0] count;
    logic shift_empty;
  } tx_stat_t;

  typedef struct packed {
    logic xoff;
    logic xon;
    logic special;
    logic rts_rise;
    logic cts_rise;
  } flow_evt_t;

  typedef struct packed {
    logic [3:0] lines;
    logic [3:0] delta;
  } modem_t;

endpackage

// *** hw/sticky_flag.sv ***
module sticky_flag
  import uart_irq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_q
);

  logic q_reg;
  logic q_next;

  // set beats clear so an event in the clearing cycle survives
  assign q_next = i_set | (q_reg & ~i_clr);
  assign o_q = q_reg;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule

// *** hw/uart_interrupt_enable_status.sv ***
//
// Contract
// - fifo mode rx-available interrupt follows fill at or above trigger level.
// - data-ready line flag set on first stored character, clear when empty.
// - fifo on with enables 0-3 clear gives polled operation via line flags.
// - line status bits report overrun, head errors, transmit empties, any error.
// - enable bit 0 raises rx-ready on held character or trigger level.
// - enable bit 1 raises tx-ready on empty or below trigger; enabling when empty too.
// - overrun interrupts at once; head-byte errors interrupt when they reach the head.
// - enable bit 3 raises modem interrupt on any delta flag.
// - enable bits 4-7 writable only with enhanced enable; bit 4 is sleep.
// - enable bit 5 raises interrupt on flow-stop or special character.
// - enable bit 6 interrupts on automatic rts rising edge.
// - enable bit 7 interrupts on automatic cts rising edge.
// - status read shows highest pending source; lower ones stay queued.
// - receive timeout fires after four characters plus twelve bit times.
// - tx-ready raised by trigger or empty; cleared by status read or write.
// - line interrupt cleared by line read, modem by modem read.
// - rx-ready clears below trigger; timeout clears on any holding read.
// - flow-stop clears on status read or resume; special on read or next char.
// - rts and cts change interrupts clear on modem status read.
// - codes 06, 0c, 04, 02 for priorities one to four.
// - codes 00, 10, 20 for priorities five to seven, 01 when idle.
// - status bit 0 low while pending, high when idle and after reset.
// - status bits 7:6 both follow fifo enable.
// - status bits 4 and 5 reported only with enhanced enable.
module uart_interrupt_enable_status
  import uart_irq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire rx_stat_t i_rx,
  input wire tx_stat_t i_tx,
  input wire flow_evt_t i_flow,
  input wire modem_t i_modem,
  output logic [7:0] o_rd_data,
  output logic o_irq,
  output logic o_rx_pop,
  output logic o_tx_push,
  output logic [7:0] o_tx_data,
  output logic o_rx_fifo_reset,
  output logic o_tx_fifo_reset,
  output logic o_fifo_en,
  output logic o_sleep_en,
  output logic o_auto_rts_en,
  output logic o_auto_cts_en
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] ier_reg;
  logic [7:0] ier_next;
  logic [7:0] efr_reg;
  logic [7:0] lcr_reg;
  logic [7:0] fcr_reg;
  logic [7:0] fcr_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic tx_push_reg;
  logic [7:0] tx_data_reg;
  logic rx_rst_reg;
  logic tx_rst_reg;
  logic [6:0] tout_cnt_reg;
  logic [6:0] tout_cnt_next;
  logic tout_armed_reg;
  logic tout_armed_next;
  logic tx_lvl_reg;
  logic head_bad_reg;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire rd_en = i_cs & i_rd;
  wire wr_en = i_cs & i_wr;
  wire enh_key = (lcr_reg == LCR_ENHANCED_KEY);
  wire div_sel = lcr_reg[LC_DIV];
  wire enh_en = efr_reg[EF_ENH];
  wire fifo_en = fcr_reg[FC_EN];
  wire hold_sel = (i_addr == ADDR_HOLDING) & ~div_sel;
  wire ier_sel = (i_addr == ADDR_ENABLE) & ~div_sel;
  wire stat_sel = (i_addr == ADDR_STATUS) & ~enh_key;
  wire efr_sel = (i_addr == ADDR_STATUS) & enh_key;
  wire lcr_sel = (i_addr == ADDR_LINE_CTRL);
  wire lsr_sel = (i_addr == ADDR_LINE_STATUS) & ~enh_key;
  wire msr_sel = (i_addr == ADDR_MODEM_STATUS);
  wire rhr_read = rd_en & hold_sel;
  wire thr_write = wr_en & hold_sel;
  wire isr_read = rd_en & stat_sel;
  wire lsr_read = rd_en & lsr_sel;
  wire msr_read = rd_en & msr_sel;

  // ----------------------------------------------------------------
  // trigger levels
  // ----------------------------------------------------------------
  logic [5:0] rx_trig;
  logic [5:0] tx_trig;

  always_comb begin
    case (fcr_reg[7:6])
      2'h0: rx_trig = RX_TRIG_0;
      2'h1: rx_trig = RX_TRIG_1;
      2'h2: rx_trig = RX_TRIG_2;
      2'h3: rx_trig = RX_TRIG_3;
      default: rx_trig = RX_TRIG_0;
    endcase
    case (fcr_reg[5:4])
      2'h0: tx_trig = TX_TRIG_0;
      2'h1: tx_trig = TX_TRIG_1;
      2'h2: tx_trig = TX_TRIG_2;
      2'h3: tx_trig = TX_TRIG_3;
      default: tx_trig = TX_TRIG_0;
    endcase
  end

  // ----------------------------------------------------------------
  // source levels
  // ----------------------------------------------------------------
  wire rx_nonempty = (i_rx.count != 6'h00);
  wire rx_at_trig = fifo_en ? (i_rx.count >= rx_trig) : rx_nonempty;
  wire tx_empty = (i_tx.count == 6'h00);
  // empty also counts in fifo mode: a reload that never passed the trigger
  wire tx_lvl = fifo_en ? ((i_tx.count < tx_trig) | tx_empty) : tx_empty;
  wire head_bad = rx_nonempty & (|i_rx.head_err);
  wire tx_rise = tx_lvl & ~tx_lvl_reg;
  wire ier_tx_on = wr_en & ier_sel & i_wr_data[IE_TX] & ~ier_reg[IE_TX];

  // ----------------------------------------------------------------
  // priority encode of pending sources
  // ----------------------------------------------------------------
  logic line_flag;
  logic ovr_flag;
  logic tout_flag;
  logic tx_flag;
  logic xoff_flag;
  logic spec_flag;
  logic rts_flag;
  logic cts_flag;
  logic [3:0] delta_flag;

  wire p_line = ier_reg[IE_LINE] & line_flag;
  wire p_tout = ier_reg[IE_RX] & fifo_en & tout_flag;
  wire p_receive_ready_event = ier_reg[IE_RX] & rx_at_trig;
  wire p_tx = ier_reg[IE_TX] & tx_flag;
  wire p_modem = ier_reg[IE_MODEM] & (|delta_flag);
  wire p_xoff = enh_en & ier_reg[IE_XOFF] & (xoff_flag | spec_flag);
  wire p_flow = enh_en & ((ier_reg[IE_RTS] & rts_flag) | (ier_reg[IE_CTS] & cts_flag));
  wire any_pend = p_line | p_tout | p_receive_ready_event | p_tx | p_modem | p_xoff | p_flow;

  logic [5:0] isr_code;

  // fixed order; lower sources wait until the higher one is cleared
  always_comb begin
    if (p_line) begin
      isr_code = CODE_LINE;
    end else if (p_tout) begin
      isr_code = CODE_TIMEOUT;
    end else if (p_receive_ready_event) begin
      isr_code = CODE_RECEIVE_READY_EVENT;
    end else if (p_tx) begin
      isr_code = CODE_TRANSMIT_READY_EVENT;
    end else if (p_modem) begin
      isr_code = CODE_MODEM;
    end else if (p_xoff) begin
      isr_code = CODE_XOFF;
    end else if (p_flow) begin
      isr_code = CODE_FLOW;
    end else begin
      isr_code = CODE_NONE;
    end
  end

  wire [7:0] isr_val = {fifo_en, fifo_en, isr_code};
  // a status read only acknowledges the source that it actually returned
  wire isr_ack_tx = isr_read & (isr_code == CODE_TRANSMIT_READY_EVENT);
  wire isr_ack_xoff = isr_read & (isr_code == CODE_XOFF);

  // frame bits = start + data + stop, plus parity and the extra stop bit
  wire [6:0] frame_bits = FRAME_BASE_BITS - 7'h1 + {5'h0, lcr_reg[1:0]} + 7'h1
    + {6'h0, lcr_reg[LC_PAR]} + {6'h0, lcr_reg[LC_STOP]};
  wire [6:0] tout_span = 7'(frame_bits * TOUT_CHARS) + TOUT_EXTRA_BITS;

  // ----------------------------------------------------------------
  // sticky sources
  // ----------------------------------------------------------------
  sticky_flag u_line (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(i_rx.overrun | (head_bad & ~head_bad_reg)),
    .i_clr(lsr_read),
    .o_q(line_flag)
  );
  sticky_flag u_ovr (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(i_rx.overrun),
    .i_clr(lsr_read),
    .o_q(ovr_flag)
  );
  sticky_flag u_tout (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(tout_armed_reg & (tout_cnt_reg >= tout_span) & ~rhr_read),
    .i_clr(rhr_read),
    .o_q(tout_flag)
  );
  sticky_flag u_tx (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(tx_rise | (ier_tx_on & tx_lvl)),
    .i_clr(isr_ack_tx | thr_write),
    .o_q(tx_flag)
  );
  sticky_flag u_xoff (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(i_flow.xoff),
    .i_clr(isr_ack_xoff | i_flow.xon),
    .o_q(xoff_flag)
  );
  sticky_flag u_spec (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(i_flow.special),
    .i_clr(isr_ack_xoff | i_rx.push),
    .o_q(spec_flag)
  );
  sticky_flag u_rts (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(i_flow.rts_rise & efr_reg[EF_RTS]),
    .i_clr(msr_read),
    .o_q(rts_flag)
  );
  sticky_flag u_cts (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_set(i_flow.cts_rise & efr_reg[EF_CTS]),
    .i_clr(msr_read),
    .o_q(cts_flag)
  );

  // one flag per modem delta, all cleared by a modem status read
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_delta
      sticky_flag u_delta (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(i_modem.delta[gi]),
        .i_clr(msr_read),
        .o_q(delta_flag[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // receive timeout timer
  // ----------------------------------------------------------------
  // restarts on any fifo movement; fires once per idle stretch
  always_comb begin
    tout_cnt_next = tout_cnt_reg;
    tout_armed_next = tout_armed_reg;
    if (~rx_nonempty | i_rx.push | rhr_read) begin
      tout_cnt_next = 7'h00;
      tout_armed_next = rx_nonempty | i_rx.push;
    end else if (tout_armed_reg & (tout_cnt_reg >= tout_span)) begin
      tout_armed_next = 1'b0;
    end else if (i_rx.bit_tick & tout_armed_reg) begin
      tout_cnt_next = tout_cnt_reg + 7'h1;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // upper enables only move while the enhanced enable is set
  assign ier_next = enh_en ? i_wr_data : ((ier_reg & ~IE_BASIC_MASK) |
    (i_wr_data & IE_BASIC_MASK));
  // fifo control bits other than the enable need the enable in the same write
  assign fcr_next = ~i_wr_data[FC_EN] ? RST_BYTE :
    {i_wr_data[7:6], enh_en ? i_wr_data[5:4] : fcr_reg[5:4], 4'h1};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ier_reg <= RST_BYTE;
      efr_reg <= RST_BYTE;
      lcr_reg <= RST_BYTE;
      fcr_reg <= RST_BYTE;
    end else begin
      if (wr_en & ier_sel) begin
        ier_reg <= ier_next;
      end
      if (wr_en & efr_sel) begin
        efr_reg <= i_wr_data;
      end
      if (wr_en & lcr_sel) begin
        lcr_reg <= i_wr_data;
      end
      if (wr_en & stat_sel) begin
        fcr_reg <= fcr_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] lsr_val = {i_rx.any_err, tx_empty & i_tx.shift_empty, tx_empty,
    rx_nonempty ? i_rx.head_err : 3'h0, ovr_flag, rx_nonempty};

  always_comb begin
    rd_data_next = RST_BYTE;
    if (hold_sel) begin
      rd_data_next = i_rx.head_data;
    end else if (ier_sel) begin
      rd_data_next = ier_reg;
    end else if (efr_sel) begin
      rd_data_next = efr_reg;
    end else if (stat_sel) begin
      rd_data_next = isr_val;
    end else if (lcr_sel) begin
      rd_data_next = lcr_reg;
    end else if (lsr_sel) begin
      rd_data_next = lsr_val;
    end else if (msr_sel) begin
      rd_data_next = {i_modem.lines, delta_flag};
    end
  end

  // ----------------------------------------------------------------
  // answer, strobes and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_reg <= RST_BYTE;
      tx_push_reg <= 1'b0;
      tx_data_reg <= RST_BYTE;
      rx_rst_reg <= 1'b0;
      tx_rst_reg <= 1'b0;
      tout_cnt_reg <= 7'h00;
      tout_armed_reg <= 1'b0;
      tx_lvl_reg <= 1'b1;
      head_bad_reg <= 1'b0;
    end else begin
      if (rd_en) begin
        rd_data_reg <= rd_data_next;
      end
      tx_push_reg <= thr_write;
      if (thr_write) begin
        tx_data_reg <= i_wr_data;
      end
      rx_rst_reg <= wr_en & stat_sel & i_wr_data[FC_EN] & i_wr_data[FC_RXRST];
      tx_rst_reg <= wr_en & stat_sel & i_wr_data[FC_EN] & i_wr_data[FC_TXRST];
      tout_cnt_reg <= tout_cnt_next;
      tout_armed_reg <= tout_armed_next;
      tx_lvl_reg <= tx_lvl;
      head_bad_reg <= head_bad;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rd_data = rd_data_reg;
  assign o_irq = any_pend;
  assign o_rx_pop = rhr_read;
  assign o_tx_push = tx_push_reg;
  assign o_tx_data = tx_data_reg;
  assign o_rx_fifo_reset = rx_rst_reg;
  assign o_tx_fifo_reset = tx_rst_reg;
  assign o_fifo_en = fifo_en;
  assign o_sleep_en = ier_reg[IE_SLEEP];
  assign o_auto_rts_en = efr_reg[EF_RTS];
  assign o_auto_cts_en = efr_reg[EF_CTS];

endmodule

// *** test/uie_asserts.sv ***
module uie_asserts
  import uart_irq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire rx_stat_t i_rx,
  input wire tx_stat_t i_tx,
  input wire modem_t i_modem,
  input wire logic [7:0] o_rd_data,
  input wire logic o_irq,
  input wire logic o_rx_pop,
  input wire logic o_tx_push,
  input wire logic [7:0] o_tx_data,
  input wire logic o_fifo_en
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // shadow of host writes
  // ----------------------------------------------------------------
  logic [7:0] lcr_reg;
  logic [3:0] ie_reg;
  wire logic lcr_wr = i_cs && i_wr && (i_addr == ADDR_LINE_CTRL);
  wire logic ie_wr = i_cs && i_wr && (i_addr == ADDR_ENABLE) && !lcr_reg[7];

  // only the low enables are mirrored; the upper ones hang on the key
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lcr_reg <= 8'h00;
      ie_reg <= 4'h0;
    end else begin
      lcr_reg <= lcr_wr ? i_wr_data : lcr_reg;
      ie_reg <= ie_wr ? i_wr_data[3:0] : ie_reg;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence stat_rd_s;
    i_cs && i_rd && (i_addr == ADDR_STATUS) && !lcr_reg[7];
  endsequence
  sequence hold_wr_s;
    i_cs && i_wr && (i_addr == ADDR_HOLDING) && !lcr_reg[7];
  endsequence

  read_hold_a: assert property (!(i_cs && i_rd) |=> $stable(o_rd_data))
    else $error("read data moved without a read");
  idle_bit_a: assert property (stat_rd_s |=> o_rd_data[0] == !$past(o_irq))
    else $error("status bit 0 disagrees with irq");
  fifo_bits_a: assert property (stat_rd_s |=> o_rd_data[7:6] == {2{$past(o_fifo_en)}})
    else $error("status bits 7:6 disagree with fifo enable");
  pop_cause_a: assert property (o_rx_pop |-> i_cs && i_rd && (i_addr == ADDR_HOLDING))
    else $error("pop without holding read");
  push_data_a: assert property (hold_wr_s |=> o_tx_push && (o_tx_data == $past(i_wr_data)))
    else $error("holding write not pushed");
  modem_irq_a: assert property (ie_reg[IE_MODEM] && (|i_modem.delta) |=> o_irq)
    else $error("modem change gave no irq");
  line_irq_a: assert property (ie_reg[IE_LINE] && i_rx.overrun |=> o_irq)
    else $error("overrun gave no irq");
  rx_ready_a: assert property (ie_reg[IE_RX] && !o_fifo_en && (i_rx.count != 6'h00) ##1
    (i_rx.count != 6'h00) && !o_fifo_en && ie_reg[IE_RX] |-> o_irq)
    else $error("held character gave no irq");
  tx_enable_a: assert property (ie_wr && i_wr_data[IE_TX] && !ie_reg[IE_TX]
    && (i_tx.count == 6'h00) && i_tx.shift_empty |-> ##[1:2] o_irq)
    else $error("tx enable on empty gave no irq");
endmodule

bind uart_interrupt_enable_status uie_asserts uie_asserts_i (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_cs(i_cs), .i_rd(i_rd), .i_wr(i_wr),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_rx(i_rx), .i_tx(i_tx), .i_modem(i_modem),
  .o_rd_data(o_rd_data), .o_irq(o_irq), .o_rx_pop(o_rx_pop), .o_tx_push(o_tx_push),
  .o_tx_data(o_tx_data), .o_fifo_en(o_fifo_en)
);

// *** test/chan_model.sv ***
module chan_model
  import uart_irq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_add,
  input wire logic i_ovr,
  input wire logic i_rx_pop,
  input wire logic i_tx_push,
  output rx_stat_t o_rx,
  output tx_stat_t o_tx
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // channel fifo fill model
  // ----------------------------------------------------------------
  logic [5:0] rx_cnt_reg;
  logic [5:0] tx_cnt_reg;
  logic push_reg;
  logic tick_reg;
  wire logic pop_ok = i_rx_pop && (rx_cnt_reg != 6'h00);
  wire logic [5:0] rx_cnt_next = rx_cnt_reg + {5'h00, i_add} - {5'h00, pop_ok};

  // transmitter never drains, so one holding write keeps it non-empty
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_cnt_reg <= 6'h00;
      tx_cnt_reg <= 6'h00;
      push_reg <= 1'h0;
      tick_reg <= 1'h0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      tx_cnt_reg <= tx_cnt_reg + {5'h00, i_tx_push};
      push_reg <= i_add;
      tick_reg <= !tick_reg;
    end
  end

  // bit time is two clocks: tick high every other cycle
  assign o_rx = '{count: rx_cnt_reg, push: push_reg, head_data: {2'h0, rx_cnt_reg},
    head_err: 3'h0, any_err: 1'h0, overrun: i_ovr, bit_tick: tick_reg};
  assign o_tx = '{count: tx_cnt_reg, shift_empty: tx_cnt_reg == 6'h00};
endmodule

// *** test/tb_top.sv ***
module tb_top
  import uart_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic clk, rst, cs, rd_en, wr_en, add, ovr;
  logic [2:0] addr;
  logic [7:0] wdata, got, rd_data, tx_data;
  flow_evt_t flow;
  modem_t modem;
  rx_stat_t rx;
  tx_stat_t tx;
  logic irq, pop, push;
  int fails, n_compared;

  uart_interrupt_enable_status uart_interrupt_enable_status_i (
    .i_mclk(clk), .i_rst(rst), .i_cs(cs), .i_rd(rd_en), .i_wr(wr_en), .i_addr(addr),
    .i_wr_data(wdata), .i_rx(rx), .i_tx(tx), .i_flow(flow), .i_modem(modem),
    .o_rd_data(rd_data), .o_irq(irq), .o_rx_pop(pop), .o_tx_push(push),
    .o_tx_data(tx_data), .o_rx_fifo_reset(), .o_tx_fifo_reset(), .o_fifo_en(),
    .o_sleep_en(), .o_auto_rts_en(), .o_auto_cts_en()
  );
  chan_model chan_model_i (
    .i_mclk(clk), .i_rst(rst), .i_add(add), .i_ovr(ovr), .i_rx_pop(pop),
    .i_tx_push(push), .o_rx(rx), .o_tx(tx)
  );

  // ----------------------------------------------------------------
  // bus and event tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  // one strobe cycle, then a quiet cycle so strobes never merge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    {cs, wr_en, addr, wdata} = {2'h3, a, d};
    @(negedge clk);
    {cs, wr_en} = 2'h0;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    {cs, rd_en, addr} = {2'h3, a};
    @(negedge clk);
    {cs, rd_en} = 2'h0;
    check(what, exp, rd_data);
  endtask

  task automatic ev(input logic [4:0] f, input logic [3:0] dm, input logic a, input logic o);
    @(negedge clk);
    {flow, modem.delta, add, ovr} = {f, dm, a, o};
    @(negedge clk);
    {flow, modem.delta, add, ovr} = '0;
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #2 clk = !clk;
  end

  // runs take a few hundred cycles; this limit only catches a hang
  initial begin
    repeat (3000) @(posedge clk);
    $display("watchdog expired");
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {fails, n_compared} = '0;
    {rst, cs, rd_en, wr_en, add, ovr, addr, wdata, flow, modem} = '0;
    rst = 1'h1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    rdc(ADDR_ENABLE, 8'h00, "enable reset");
    rdc(ADDR_STATUS, 8'h01, "status reset");
    check("irq reset", 8'h00, {7'h00, irq});
    $display("test reset done");
    wr(ADDR_ENABLE, 8'h02);
    rdc(ADDR_STATUS, {2'h0, CODE_TRANSMIT_READY_EVENT}, "tx code");
    rdc(ADDR_STATUS, 8'h01, "tx cleared by status");
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_ENABLE, 8'h02);
    wr(ADDR_HOLDING, 8'h5a);
    rdc(ADDR_STATUS, 8'h01, "tx cleared by write");
    $display("test transmit done");
    wr(ADDR_ENABLE, 8'hff);
    rdc(ADDR_ENABLE, 8'h0f, "upper enables locked");
    wr(ADDR_LINE_CTRL, LCR_ENHANCED_KEY);
    wr(ADDR_STATUS, 8'hd0);
    wr(ADDR_LINE_CTRL, 8'h00);
    wr(ADDR_ENABLE, 8'he8);
    rdc(ADDR_ENABLE, 8'he8, "upper enables open");
    ev(5'h11, 4'h1, 1'h0, 1'h0);
    rdc(ADDR_STATUS, {2'h0, CODE_MODEM}, "modem first");
    rdc(ADDR_MODEM_STATUS, 8'h01, "modem delta");
    rdc(ADDR_STATUS, {2'h0, CODE_XOFF}, "xoff queued");
    rdc(ADDR_STATUS, 8'h01, "xoff and cts cleared");
    ev(5'h02, 4'h0, 1'h0, 1'h0);
    rdc(ADDR_STATUS, {2'h0, CODE_FLOW}, "rts code");
    rdc(ADDR_MODEM_STATUS, 8'h00, "modem no delta");
    rdc(ADDR_STATUS, 8'h01, "rts cleared");
    ev(5'h01, 4'h0, 1'h0, 1'h0);
    rdc(ADDR_STATUS, {2'h0, CODE_FLOW}, "cts code");
    rdc(ADDR_MODEM_STATUS, 8'h00, "cts modem read");
    ev(5'h10, 4'h0, 1'h0, 1'h0);
    ev(5'h08, 4'h0, 1'h0, 1'h0);
    rdc(ADDR_STATUS, 8'h01, "xoff cleared by resume");
    ev(5'h04, 4'h0, 1'h0, 1'h0);
    rdc(ADDR_STATUS, {2'h0, CODE_XOFF}, "special code");
    ev(5'h04, 4'h0, 1'h0, 1'h0);
    ev(5'h00, 4'h0, 1'h1, 1'h0);
    rdc(ADDR_STATUS, 8'h01, "special cleared by char");
    rdc(ADDR_HOLDING, 8'h01, "holding pop");
    wr(ADDR_ENABLE, 8'h00);
    $display("test enhanced done");
    wr(ADDR_ENABLE, 8'h04);
    ev(5'h00, 4'h0, 1'h0, 1'h1);
    rdc(ADDR_STATUS, {2'h0, CODE_LINE}, "line code");
    rdc(ADDR_LINE_STATUS, 8'h02, "line overrun");
    rdc(ADDR_STATUS, 8'h01, "line cleared");
    wr(ADDR_ENABLE, 8'h00);
    $display("test line done");
    wr(ADDR_ENABLE, 8'h01);
    ev(5'h00, 4'h0, 1'h1, 1'h0);
    rdc(ADDR_STATUS, {2'h0, CODE_RECEIVE_READY_EVENT}, "rx held char");
    wr(ADDR_STATUS, 8'h01);
    rdc(ADDR_STATUS, 8'hc1, "fifo below trigger");
    repeat (7) ev(5'h00, 4'h0, 1'h1, 1'h0);
    rdc(ADDR_STATUS, {2'h3, CODE_RECEIVE_READY_EVENT}, "rx trigger");
    rdc(ADDR_LINE_STATUS, 8'h01, "data ready flag");
    rdc(ADDR_HOLDING, 8'h08, "holding read");
    rdc(ADDR_STATUS, 8'hc1, "rx below trigger");
    repeat (60) @(posedge clk);
    rdc(ADDR_STATUS, 8'hc1, "timeout not early");
    repeat (30) @(posedge clk);
    rdc(ADDR_STATUS, {2'h3, CODE_TIMEOUT}, "timeout code");
    rdc(ADDR_HOLDING, 8'h07, "holding read");
    rdc(ADDR_STATUS, 8'hc1, "timeout cleared");
    wr(ADDR_ENABLE, 8'h00);
    check("irq polled", 8'h00, {7'h00, irq});
    rdc(ADDR_LINE_STATUS, 8'h01, "polled ready");
    $display("test receive done");
    wrap_up();
  end
endmodule
